// file: design/thermal_alarm_comparator.v
// thermal alarm comparator with register slave and serial timeout watchdog
`timescale 1ns/10ps
`include "thermal_alarm_regs.vh"

module thermal_alarm_comparator #(
  parameter CONV_CYCLES = `CONV_CYCLES,
  parameter TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
  // clock and reset
  input wire CORE_CLK,
  input wire RST_N,
  // converter result, one per conversion
  input wire [8:0] ADC_TEMP,
  // two-wire link pins
  input wire SCL_IN,
  input wire SDA_IN,
  output reg SDA_OUT,
  output reg SDA_OE_N,
  output reg LINK_RESET,
  // alarm open-drain pin
  output reg ALARM_OUT,
  output reg ALARM_OE_N,
  // low-power state indicator
  output reg HALTED,
  // axi4-lite write address
  input wire [4:0] AWADDR,
  input wire AWVALID,
  output reg AWREADY,
  // axi4-lite write data
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output reg WREADY,
  // axi4-lite write response
  output reg [1:0] BRESP,
  output reg BVALID,
  input wire BREADY,
  // axi4-lite read address
  input wire [4:0] ARADDR,
  input wire ARVALID,
  output reg ARREADY,
  // axi4-lite read data
  output reg [31:0] RDATA,
  output reg [1:0] RRESP,
  output reg RVALID,
  input wire RREADY
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // fault queue code to consecutive count
  function [2:0] queue_len;
    input [1:0] code;
    begin
      case (code)
        2'b00: queue_len = 3'd1;
        2'b01: queue_len = 3'd2;
        2'b10: queue_len = 3'd4;
        default: queue_len = 3'd6;
      endcase
    end
  endfunction

  // signed greater-than on 9-bit values
  function gt9;
    input [8:0] a;
    input [8:0] b;
    begin
      gt9 = ($signed(a) > $signed(b));
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  reg [7:0] conf_q; // configuration
  reg [8:0] temp_q; // latest stored result
  reg [8:0] tos_q; // upper trip limit
  reg [8:0] hys_q; // lower release limit
  reg [31:0] conv_cnt_q; // conversion period timer
  reg [2:0] fault_cnt_q; // consecutive fault count
  reg pending_q; // queue met, wait one period
  reg alarm_q; // logical alarm state
  reg want_low_q; // interrupt mode: next event is lower
  reg halt_q; // standby reached
  reg rd_clear; // a mapped register read address was accepted last cycle
  reg [8:0] adc_s1_q; // converter input synchroniser
  reg [8:0] adc_s2_q;
  // limit reset values, 16-bit register form; only bits 15..7 are kept
  localparam [15:0] TOS_RST16 = `TOS_RESET;
  localparam [15:0] HYS_RST16 = `HYS_RESET;

  wire halt_bit = conf_q[`CONF_HALT];
  wire int_mode = conf_q[`CONF_MODE];
  wire [2:0] qlen = queue_len({conf_q[`CONF_FQ_HI], conf_q[`CONF_FQ_LO]});
  // conversion completes when the timer expires and device is awake
  wire conv_done = (conv_cnt_q == CONV_CYCLES - 1) && !halt_q;
  wire upper_hit = gt9(adc_s2_q, tos_q);
  wire lower_hit = gt9(hys_q, adc_s2_q);
  // the event being looked for depends on mode and current state
  // interrupt starts on upper event
  wire look_low = int_mode ? want_low_q : alarm_q;
  wire fault_now = look_low ? lower_hit : upper_hit;

  ////////////////////////////////////////////////////////////////////////////
  // converter input synchroniser, analog side is another domain
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      adc_s1_q <= 9'h000;
      adc_s2_q <= 9'h000;
    end else begin
      adc_s1_q <= ADC_TEMP;
      adc_s2_q <= adc_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion timer and halt sequencing
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      conv_cnt_q <= 32'h0000_0000;
      halt_q <= 1'b0;
      temp_q <= 9'h000;
    end else begin
      if (halt_q) begin
        conv_cnt_q <= 32'h0000_0000;
        halt_q <= halt_bit;
      end else if (conv_done) begin
        conv_cnt_q <= 32'h0000_0000;
        halt_q <= halt_bit;
      end else begin
        conv_cnt_q <= conv_cnt_q + 32'h0000_0001;
      end
      // store latest, reads see old value
      if (conv_done) begin
        temp_q <= adc_s2_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarm state machine
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      fault_cnt_q <= 3'd0;
      pending_q <= 1'b0;
      alarm_q <= 1'b0;
      want_low_q <= 1'b0;
    end else begin
      if (conv_done) begin
        if (pending_q) begin
          pending_q <= 1'b0;
          fault_cnt_q <= 3'd0;
          if (fault_now) begin
            if (int_mode) begin
              alarm_q <= 1'b1;
              want_low_q <= ~want_low_q;
            end else begin
              alarm_q <= ~alarm_q;
            end
          end
        end else if (fault_now && !(int_mode && alarm_q)) begin
          if (fault_cnt_q + 3'd1 >= qlen) begin
            pending_q <= 1'b1;
          end else begin
            fault_cnt_q <= fault_cnt_q + 3'd1;
          end
        end else begin
          fault_cnt_q <= 3'd0;
        end
      end
      // read or halt clears interrupt alarm
      if (int_mode && (rd_clear || halt_bit) && !(conv_done && pending_q && fault_now)) begin
        alarm_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarm pin drive, open drain with polarity
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ALARM_OUT <= 1'b0;
      ALARM_OE_N <= 1'b1;
      HALTED <= 1'b0;
    end else begin
      ALARM_OUT <= 1'b0;
      // pull low when active level is low
      ALARM_OE_N <= (alarm_q ^ conf_q[`CONF_POL]) ? 1'b0 : 1'b1;
      HALTED <= halt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link watchdog: synchronise pins, detect start/stop, time data low
  reg [1:0] scl_s_q;
  reg [1:0] sda_s_q;
  reg sda_prev_q;
  reg in_frame_q;
  reg [31:0] low_cnt_q;
  wire start_cond = scl_s_q[1] && sda_prev_q && !sda_s_q[1];
  wire stop_cond = scl_s_q[1] && !sda_prev_q && sda_s_q[1];

  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      scl_s_q <= 2'b11;
      sda_s_q <= 2'b11;
      sda_prev_q <= 1'b1;
      in_frame_q <= 1'b0;
      low_cnt_q <= 32'h0000_0000;
      LINK_RESET <= 1'b0;
      SDA_OUT <= 1'b0;
      SDA_OE_N <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], SCL_IN};
      sda_s_q <= {sda_s_q[0], SDA_IN};
      sda_prev_q <= sda_s_q[1];
      LINK_RESET <= 1'b0;
      if (start_cond) begin
        in_frame_q <= 1'b1;
        low_cnt_q <= 32'h0000_0000;
      end else if (stop_cond) begin
        in_frame_q <= 1'b0;
      end else if (in_frame_q && !sda_s_q[1]) begin
        if (low_cnt_q >= TIMEOUT_CYCLES) begin
          in_frame_q <= 1'b0;
          LINK_RESET <= 1'b1;
          low_cnt_q <= 32'h0000_0000;
        end else begin
          low_cnt_q <= low_cnt_q + 32'h0000_0001;
        end
      end else begin
        low_cnt_q <= 32'h0000_0000;
      end
      // bus released; transfer engine lives outside this block
      SDA_OE_N <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel
  reg aw_got_q;
  reg w_got_q;
  reg [4:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;

  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= 5'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= 2'b00;
      conf_q <= `CONF_RESET;
      tos_q <= TOS_RST16[`TEMP_MSB:`TEMP_LSB];
      hys_q <= HYS_RST16[`TEMP_MSB:`TEMP_LSB];
    end else begin
      AWREADY <= !aw_got_q && !AWREADY && !BVALID;
      WREADY <= !w_got_q && !WREADY && !BVALID;
      if (AWVALID && AWREADY) begin
        aw_got_q <= 1'b1;
        aw_addr_q <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_got_q <= 1'b1;
        w_data_q <= WDATA;
        w_strb_q <= WSTRB;
      end
      if (aw_got_q && w_got_q && !BVALID) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= 2'b00;
        case (aw_addr_q[4:2])
          3'd1: begin
            if (w_strb_q[0]) begin
              conf_q <= w_data_q[7:0] & `CONF_WMASK;
            end
          end
          3'd2: begin
            if (w_strb_q[1]) begin
              hys_q <= w_data_q[15:7];
            end
          end
          3'd3: begin
            if (w_strb_q[1]) begin
              tos_q <= w_data_q[15:7];
            end
          end
          3'd0: BRESP <= 2'b10; // read-only
          default: BRESP <= 2'b10; // status read-only, rest unmapped
        endcase
      end
      if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel; accepted read of a mapped register clears interrupt alarm
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= 2'b00;
      rd_clear <= 1'b0;
    end else begin
      ARREADY <= !ARREADY && !RVALID;
      rd_clear <= 1'b0;
      if (ARVALID && ARREADY) begin
        RVALID <= 1'b1;
        RRESP <= 2'b00;
        rd_clear <= 1'b1;
        case (ARADDR[4:2])
          3'd0: RDATA <= {16'h0000, temp_q, 7'h00};
          3'd1: RDATA <= {24'h00_0000, conf_q};
          3'd2: RDATA <= {16'h0000, hys_q, 7'h00};
          3'd3: RDATA <= {16'h0000, tos_q, 7'h00};
          3'd4: RDATA <= {31'h0000_0000, halt_q};
          default: begin
            RDATA <= 32'h0000_0000;
            RRESP <= 2'b10;
            rd_clear <= 1'b0;
          end
        endcase
      end
      if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

endmodule // thermal_alarm_comparator

// file: design/thermal_alarm_regs.vh
// register offsets, field positions, reset values and timing counts
`ifndef THERMAL_ALARM_REGS_VH
`define THERMAL_ALARM_REGS_VH
// byte addresses on the register bus (pointer value times four)
`define ADDR_TEMP 4'h0
`define ADDR_CONF 4'h4
`define ADDR_HYS 4'h8
`define ADDR_TOS 4'hC
`define ADDR_CONV 5'h10
// configuration fields
`define CONF_HALT 0
`define CONF_MODE 1
`define CONF_POL 2
`define CONF_FQ_LO 3
`define CONF_FQ_HI 4
`define CONF_RESET 8'h00
`define CONF_WMASK 8'h1F
// limit reset values (16-bit register form)
`define TOS_RESET 16'h5000
`define HYS_RESET 16'h4B00
// temperature field
`define TEMP_MSB 15
`define TEMP_LSB 7
// clock 20 MHz
`define CLK_HZ 20000000
// conversion period 150 ms, longest time rounds down
`define CONV_MS 150
`define CONV_CYCLES ((`CLK_HZ / 1000) * `CONV_MS)
// bus timeout 25 ms, least time rounds up
`define TIMEOUT_MS 25
`define TIMEOUT_CYCLES ((`CLK_HZ / 1000) * `TIMEOUT_MS)
`endif

// file: bench/tac_props.sv
// port assertions for the thermal alarm comparator
`timescale 1ns/10ps
module tac_props (
  // clock and reset
  input wire CORE_CLK,
  input wire RST_N,
  // pins
  input wire SDA_OE_N,
  input wire LINK_RESET,
  input wire ALARM_OE_N,
  input wire HALTED,
  // register bus
  input wire [4:0] AWADDR,
  input wire AWVALID,
  input wire AWREADY,
  input wire [1:0] BRESP,
  input wire BVALID,
  input wire [4:0] ARADDR,
  input wire ARVALID,
  input wire ARREADY,
  input wire [31:0] RDATA,
  input wire [1:0] RRESP,
  input wire RVALID,
  input wire RREADY
);
  reg [4:0] ar_q; // last read address taken
  reg [4:0] aw_q; // last write address taken
  reg [3:0] quiet_q; // cycles since a write, saturating
  ////////////////////////////////////////////////////////////////
  // address capture, writes may legally move the alarm pin
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ar_q <= 5'h00;
      aw_q <= 5'h00;
      quiet_q <= 4'h0;
    end else begin
      if (ARVALID && ARREADY) ar_q <= ARADDR;
      if (AWVALID && AWREADY) aw_q <= AWADDR;
      if (AWVALID && AWREADY) quiet_q <= 4'h0;
      else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
    end
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  property p_sda; SDA_OE_N; endproperty
  a_sda: assert property (p_sda) else $error("data pin driven");
  property p_lrst; LINK_RESET |=> !LINK_RESET; endproperty
  a_lrst: assert property (p_lrst) else $error("link reset too long");
  property p_tmp; RVALID && ar_q == 5'h00 |-> RDATA[6:0] == 7'h00 && RDATA[31:16] == 16'h0000;
  endproperty
  a_tmp: assert property (p_tmp) else $error("temp low bits set");
  property p_bad; RVALID && ar_q[4:2] > 3'd4 |-> RRESP == 2'b10 && RDATA == 32'h0000_0000;
  endproperty
  a_bad: assert property (p_bad) else $error("unmapped read ok");
  property p_wro; BVALID && aw_q[4:2] == 3'd0 |-> BRESP == 2'b10; endproperty
  a_wro: assert property (p_wro) else $error("temp write accepted");
  property p_hold; RVALID && !RREADY |=> RVALID && $stable(RDATA); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_ans; ARVALID && ARREADY |=> RVALID; endproperty
  a_ans: assert property (p_ans) else $error("read answer late");
  property p_halt; HALTED && $past(HALTED) && quiet_q > 4'h4 |-> $stable(ALARM_OE_N); endproperty
  a_halt: assert property (p_halt) else $error("alarm moved in halt");
  c_lrst: cover property (LINK_RESET);
  c_halt: cover property ($rose(HALTED));
  c_alarm: cover property ($fell(ALARM_OE_N));
endmodule // tac_props
bind thermal_alarm_comparator tac_props i_props (.CORE_CLK, .RST_N, .SDA_OE_N, .LINK_RESET,
  .ALARM_OE_N, .HALTED, .AWADDR, .AWVALID, .AWREADY, .BRESP, .BVALID, .ARADDR, .ARVALID,
  .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY);

// file: bench/link_master_model.sv
// two-wire master model, clock stands high between frames
`timescale 1ns/10ps
module link_master_model (
  // link pins, 1 = released
  output reg scl,
  output reg sda,
  // timeout pulse count
  input wire link_reset,
  output integer n_rst
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    n_rst = 0;
  end
  always @(posedge link_reset) n_rst = n_rst + 1;
  // start, n clock periods of 400 ns with data low, then stop
  task frame(input integer n);
    begin
      #213 sda = 1'b0;
      repeat (n) begin
        #200 scl = 1'b0;
        #200 scl = 1'b1;
      end
      #200 sda = 1'b1;
    end
  endtask
endmodule // link_master_model

// file: bench/thermal_alarm_comparator_bench.sv
// self-checking bench for the thermal alarm comparator
`timescale 1ns/10ps
module thermal_alarm_comparator_bench;
  localparam CP = 50; // shortened conversion period
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [8:0] temp = 9'h000;
  reg [4:0] awaddr = 5'h00, araddr = 5'h00;
  reg [31:0] wdata = 32'h0000_0000, rv;
  reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  wire scl, sda_m, sda_out, sda_oe_n, lrst, al_out, al_oe_n, halted;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer failures = 0, n_compared = 0, n_lrst, i;
  reg [33:0] q_r[$];
  reg [1:0] q_b[$];
  wire sda = sda_m & (sda_oe_n | sda_out); // pulled-up data line
  always #25 clk = ~clk;
  thermal_alarm_comparator #(.CONV_CYCLES(CP), .TIMEOUT_CYCLES(40)) i_dut (
    .CORE_CLK(clk), .RST_N(rst_n), .ADC_TEMP(temp), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .LINK_RESET(lrst), .ALARM_OUT(al_out),
    .ALARM_OE_N(al_oe_n), .HALTED(halted), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
  link_master_model i_link (.scl(scl), .sda(sda_m), .link_reset(lrst), .n_rst(n_lrst));
  ////////////////////////////////////////////////////////////////
  task chk_bus(input [33:0] g, input [33:0] e);
    n_compared = n_compared + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("[ERR] %0t bus got %h want %h", $time, g, e);
    end
  endtask
  task chk_pin(input g, input e);
    n_compared = n_compared + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("[ERR] %0t pin got %b want %b", $time, g, e);
    end
  endtask
  // monitor takes the oldest note as each answer lands
  always @(posedge clk) begin
    if (rvalid && rready) chk_bus({rresp, rdata}, q_r.pop_front());
    if (bvalid && bready) chk_bus({32'h0000_0000, bresp}, {32'h0000_0000, q_b.pop_front()});
  end
  task wr(input [4:0] a, input [31:0] d, input [1:0] r);
    reg aw_done;
    reg w_done;
    begin
      @(posedge clk);
      q_b.push_back(r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw_done = 1'b0;
      w_done = 1'b0;
      // local flags, the valids themselves only settle after this step
      while (!aw_done || !w_done) begin
        @(posedge clk);
        if (awready && !aw_done) begin
          awvalid <= 1'b0;
          aw_done = 1'b1;
        end
        if (wready && !w_done) begin
          wvalid <= 1'b0;
          w_done = 1'b1;
        end
      end
      while (!bvalid) @(posedge clk);
      bready <= 1'b0;
    end
  endtask
  task rd(input [4:0] a, input [33:0] e);
    @(posedge clk);
    q_r.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
  endtask
  task heat(input [8:0] t, input integer n);
    @(posedge clk);
    temp <= t;
    repeat (n * CP) @(posedge clk);
  endtask
  task summarize;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #3_000_000;
    failures = failures + 1;
    summarize;
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    rv = $urandom(32'h7f725019);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(5'h04, 34'h0);
    rd(5'h08, {2'b00, 32'h0000_4B00});
    rd(5'h0C, {2'b00, 32'h0000_5000});
    rd(5'h14, {2'b10, 32'h0000_0000});
    wr(5'h00, 32'h0000_FFFF, 2'b10);
    $display("defaults done");
    for (i = 0; i < 3; i = i + 1) begin
      rv = $urandom;
      heat(rv[8:0], 2);
      rd(5'h00, {18'h0, temp, 7'h00});
    end
    // each heat step allows one conversion of slack at either end
    heat(9'h0A1, 3);
    chk_pin(al_oe_n, 1'b0);
    chk_pin(al_out, 1'b0);
    heat(9'h0A0, 3);
    chk_pin(al_oe_n, 1'b0);
    heat(9'h095, 3);
    chk_pin(al_oe_n, 1'b1);
    $display("comparator done");
    wr(5'h04, 32'h0000_0018, 2'b00);
    heat(9'h0A1, 3);
    heat(9'h095, 2);
    heat(9'h0A1, 4);
    chk_pin(al_oe_n, 1'b1);
    heat(9'h0A1, 5);
    chk_pin(al_oe_n, 1'b0);
    wr(5'h04, 32'h0000_001C, 2'b00);
    repeat (4) @(posedge clk);
    chk_pin(al_oe_n, 1'b1);
    wr(5'h04, 32'h0000_0000, 2'b00);
    heat(9'h095, 3);
    chk_pin(al_oe_n, 1'b1);
    // four-deep queue, then two-deep queue on the way down
    wr(5'h04, 32'h0000_0010, 2'b00);
    heat(9'h0A1, 4);
    chk_pin(al_oe_n, 1'b1);
    heat(9'h0A1, 3);
    chk_pin(al_oe_n, 1'b0);
    wr(5'h04, 32'h0000_0008, 2'b00);
    heat(9'h095, 2);
    chk_pin(al_oe_n, 1'b0);
    heat(9'h095, 3);
    chk_pin(al_oe_n, 1'b1);
    $display("queue and polarity done");
    wr(5'h04, 32'h0000_0002, 2'b00);
    heat(9'h0A1, 3);
    chk_pin(al_oe_n, 1'b0);
    heat(9'h0A1, 3);
    chk_pin(al_oe_n, 1'b0);
    rd(5'h00, {2'b00, 16'h0000, 9'h0A1, 7'h00});
    repeat (3) @(posedge clk);
    chk_pin(al_oe_n, 1'b1);
    heat(9'h0A1, 3);
    chk_pin(al_oe_n, 1'b1);
    heat(9'h095, 3);
    chk_pin(al_oe_n, 1'b0);
    rd(5'h04, {2'b00, 32'h0000_0002});
    repeat (3) @(posedge clk);
    chk_pin(al_oe_n, 1'b1);
    heat(9'h0A1, 3);
    chk_pin(al_oe_n, 1'b0);
    wr(5'h04, 32'h0000_0003, 2'b00);
    repeat (2 * CP) @(posedge clk);
    chk_pin(al_oe_n, 1'b1);
    chk_pin(halted, 1'b1);
    $display("interrupt done");
    wr(5'h04, 32'h0000_0000, 2'b00);
    heat(9'h0A1, 3);
    chk_pin(al_oe_n, 1'b0);
    wr(5'h04, 32'h0000_0001, 2'b00);
    heat(9'h0A1, 2);
    heat(9'h095, 3);
    chk_pin(al_oe_n, 1'b0);
    rd(5'h00, {2'b00, 16'h0000, 9'h0A1, 7'h00});
    rd(5'h10, {2'b00, 32'h0000_0001});
    wr(5'h04, 32'h0000_0000, 2'b00);
    heat(9'h095, 3);
    chk_pin(al_oe_n, 1'b1);
    chk_pin(halted, 1'b0);
    $display("halt done");
    i_link.frame(2);
    repeat (4) @(posedge clk);
    chk_pin(n_lrst == 0, 1'b1);
    i_link.frame(10);
    repeat (4) @(posedge clk);
    chk_pin(n_lrst == 1, 1'b1);
    $display("link done");
    summarize;
  end
endmodule // thermal_alarm_comparator_bench
